// *** core/hmc_misc_config.sv ***
// host miscellaneous configuration register with its pin, clock gate,
// clock run and link-access termination logic.
// assumes single-cycle configuration read and write strobes in the host clock
// domain, and a link clock status that arrives from the link clock domain.
//
// Notes on behaviour
// (RULE_01) reserved bits always read as zero
// (RULE_02) bit 15 mirrors wake-from-cold capability
// (RULE_03) bit 13 mirrors wake-from-low-state capability
// (RULE_04) bit 10 mirrors low-state support capability
// (RULE_05) host and link logic in separate clocks
// (RULE_06) stopped link access aborts when mode clear
// (RULE_07) mode set: stopped link access returns ones
// (RULE_08) software should set the no-abort mode
// (RULE_09) bit 3 routes pins to eeprom bus
// (RULE_10) bit 3 releases both general pin drivers
// (RULE_11) bit 2 bypasses link clock gating
// (RULE_12) bit 1 bypasses host clock gating
// (RULE_13) software keeps both bypass bits zero
// (RULE_14) bit 0 keeps clock running via clock run
// (RULE_15) bit 0 clear lets clock stop
// (RULE_16) reserved writes ignored; reset value 0x00002400
`timescale 1ns/1ps
module hmc_misc_config
    import hmc_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,

    // configuration space access
    input wire logic CFG_WRITE,
    input wire logic CFG_READ,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BYTE_EN,
    input wire logic [31:0] CFG_WDATA,
    output logic CFG_READ_VALID,
    output logic [31:0] CFG_RDATA,

    // capability mirror into the power management capabilities register
    output logic WAKE_FROM_COLD_ADVERT,
    output logic WAKE_FROM_LOW_STATE_ADVERT,
    output logic LOW_STATE_ADVERT,

    // access to a link-domain register
    input wire logic LINK_ACCESS,
    input wire logic LINK_ACCESS_READ,
    input wire logic [31:0] LINK_READ_DATA,
    input wire logic LINK_CLOCK_RUNNING,
    output logic LINK_ACCESS_DONE,
    output logic LINK_TARGET_ABORT,
    output logic [31:0] LINK_ACCESS_RDATA,

    // clock gate control
    input wire logic HOST_CLOCK_GATE_REQ,
    input wire logic LINK_CLOCK_GATE_REQ,
    output logic HOST_CLOCK_GATE_OPEN,
    output logic LINK_CLOCK_GATE_OPEN,

    // clock run open-drain line
    input wire logic CLKRUN_IN,
    output logic CLKRUN_OUT,
    output logic CLKRUN_OE,

    // general pin drivers from the pin controller
    input wire logic GENERAL_PIN_THREE_DRIVE,
    input wire logic GENERAL_PIN_THREE_DRIVE_EN,
    input wire logic GENERAL_PIN_TWO_DRIVE,
    input wire logic GENERAL_PIN_TWO_DRIVE_EN,
    output logic GENERAL_PIN_THREE_SEEN,
    output logic GENERAL_PIN_TWO_SEEN,

    // general pin pads
    input wire logic GENERAL_PIN_THREE_IN,
    output logic GENERAL_PIN_THREE_OUT,
    output logic GENERAL_PIN_THREE_OE,
    input wire logic GENERAL_PIN_TWO_IN,
    output logic GENERAL_PIN_TWO_OUT,
    output logic GENERAL_PIN_TWO_OE,

    // serial eeprom two-wire lines
    input wire logic EEPROM_CLOCK_IN,
    output logic EEPROM_CLOCK_OUT,
    output logic EEPROM_CLOCK_OE,
    input wire logic EEPROM_DATA_IN,
    output logic EEPROM_DATA_OUT,
    output logic EEPROM_DATA_OE
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    // reserved flops hold constant zero and are trimmed
    logic [31:0] misc;
    logic [31:0] next_misc;
    logic [31:0] byte_mask;

    // decode: one dword at the register offset;
    // other offsets belong to neighbouring registers
    wire logic hit = (CFG_ADDR == HMC_MISC_OFFSET);
    wire logic do_write = CFG_WRITE && hit;

    // expand byte enables into a bit mask
    // lanes 2 and 3 carry only reserved bits
    always_comb begin
        byte_mask = {{8{CFG_BYTE_EN[3]}}, {8{CFG_BYTE_EN[2]}},
                     {8{CFG_BYTE_EN[1]}}, {8{CFG_BYTE_EN[0]}}};
    end

    // only enabled bytes of writable bits change; reserved bits stay zero
    assign next_misc = (misc & ~(byte_mask & HMC_WRITE_MASK))
                     | (CFG_WDATA & byte_mask & HMC_WRITE_MASK); // RULE_16

    // reset restores the advertised capabilities,
    // so they read right before software runs
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            misc <= HMC_RESET_VALUE; // RULE_16
        end else if (do_write) begin
            misc <= next_misc;
        end
    end

    // named field views for the sections below
    wire logic no_target_abort_mode = misc[HMC_BIT_NO_ABORT];
    wire logic pins_to_eeprom_bus_route = misc[HMC_BIT_PIN_ROUTE];
    wire logic link_clock_gate_bypass = misc[HMC_BIT_LINK_BYPASS];
    wire logic host_clock_gate_bypass = misc[HMC_BIT_HOST_BYPASS];
    wire logic keep_clock = misc[HMC_BIT_KEEP_CLOCK];

    ////////////////////////////////////////////////////////////////////////
    // read path

    // unmapped offsets read zero; reserved bits masked off again for safety
    wire logic [31:0] read_word = hit ? (misc & HMC_WRITE_MASK) : 32'h00000000; // RULE_01

    // data holds between reads for a late sampler;
    // valid marks the one cycle owned by the strobe
    // both clear in reset, so no stale word shows
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            CFG_READ_VALID <= 1'b0;
            CFG_RDATA <= 32'h00000000;
        end else begin
            CFG_READ_VALID <= CFG_READ;
            CFG_RDATA <= CFG_READ ? read_word : CFG_RDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power management capability mirror

    // levels go straight to the capability register;
    // a write shows there one cycle after its strobe
    // reset advertises both low-state capabilities
    assign WAKE_FROM_COLD_ADVERT = misc[HMC_BIT_WAKE_COLD]; // RULE_02
    assign WAKE_FROM_LOW_STATE_ADVERT = misc[HMC_BIT_WAKE_LOW]; // RULE_03
    assign LOW_STATE_ADVERT = misc[HMC_BIT_LOW_STATE]; // RULE_04

    ////////////////////////////////////////////////////////////////////////
    // link-domain access termination

    // link clock status crosses from the link domain through two stages
    // a level only; no pulse crosses, so two stages do
    logic link_run_meta;
    logic link_run;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            link_run_meta <= 1'b0;
            link_run <= 1'b0;
        end else begin
            link_run_meta <= LINK_CLOCK_RUNNING; // RULE_05
            link_run <= link_run_meta;
        end
    end

    // limitation: status is two cycles old, so an access
    // just after the link stops still goes to the link
    // a stopped link cannot answer, so the host side answers for it
    wire logic link_dead = !link_run;
    wire logic abort_now = LINK_ACCESS && link_dead && !no_target_abort_mode; // RULE_06
    wire logic ones_now = LINK_ACCESS && link_dead && no_target_abort_mode; // RULE_07
    wire logic [31:0] link_answer = ones_now ? HMC_ALL_ONES
                                  : (LINK_ACCESS_READ ? LINK_READ_DATA : 32'h00000000);

    // exactly one of done and abort, a cycle later
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            LINK_ACCESS_DONE <= 1'b0;
            LINK_TARGET_ABORT <= 1'b0;
            LINK_ACCESS_RDATA <= 32'h00000000;
        end else begin
            LINK_ACCESS_DONE <= LINK_ACCESS && !abort_now; // RULE_07
            LINK_TARGET_ABORT <= abort_now; // RULE_06
            LINK_ACCESS_RDATA <= LINK_ACCESS ? link_answer : LINK_ACCESS_RDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock gate bypass

    // bypass bits stay clear in products: the gated
    // clocks would then never stop and waste power
    // requests come from clock control on this clock
    // test feature: a set bypass holds the gate open whatever the request
    assign HOST_CLOCK_GATE_OPEN = host_clock_gate_bypass || HOST_CLOCK_GATE_REQ; // RULE_12
    assign LINK_CLOCK_GATE_OPEN = link_clock_gate_bypass || LINK_CLOCK_GATE_REQ; // RULE_11

    ////////////////////////////////////////////////////////////////////////
    // clock run keeper

    // the shared line is asynchronous here: two stages
    logic clkrun_meta;
    logic clkrun_sync;
    logic clkrun_pull;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            clkrun_meta <= 1'b0;
            clkrun_sync <= 1'b0;
        end else begin
            clkrun_meta <= CLKRUN_IN;
            clkrun_sync <= clkrun_meta;
        end
    end

    // the keeper only asks; the central resource decides,
    // and the clock may stop once keeping is cleared
    hmc_clock_keeper u_keeper (
        .clock(CLOCK),
        .rst(RST),
        .keep_enable(keep_clock),
        .line_high(clkrun_sync),
        .line_drive_low(clkrun_pull)
    );

    // open drain: only ever drives low
    // hazard: other agents share it, never drive high
    assign CLKRUN_OUT = 1'b0;
    assign CLKRUN_OE = clkrun_pull; // RULE_14

    ////////////////////////////////////////////////////////////////////////
    // general pin routing

    // index 1 is pin three (clock line), index 0 is pin two (data line)
    // drivers come from this clock and need no stages
    logic [1:0] pad_sync_meta;
    logic [1:0] pad_sync;
    logic [1:0] bus_sync_meta;
    logic [1:0] bus_sync;
    logic [1:0] gen_seen;
    logic [1:0] pad_out;
    logic [1:0] pad_oe;
    logic [1:0] bus_out;
    logic [1:0] bus_oe;

    // pads and eeprom lines are outside the domain
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pad_sync_meta <= 2'h0;
            pad_sync <= 2'h0;
            bus_sync_meta <= 2'h0;
            bus_sync <= 2'h0;
        end else begin
            pad_sync_meta <= {GENERAL_PIN_THREE_IN, GENERAL_PIN_TWO_IN};
            pad_sync <= pad_sync_meta;
            bus_sync_meta <= {EEPROM_CLOCK_IN, EEPROM_DATA_IN};
            bus_sync <= bus_sync_meta;
        end
    end

    // routing follows the stages, so the seen value
    // has the same two-cycle delay from either source
    // pad drivers are released while the route is on
    hmc_pin_router #(
        .COUNT(HMC_PIN_COUNT)
    ) u_router (
        .route(pins_to_eeprom_bus_route),
        .gen_out({GENERAL_PIN_THREE_DRIVE, GENERAL_PIN_TWO_DRIVE}),
        .gen_oe({GENERAL_PIN_THREE_DRIVE_EN, GENERAL_PIN_TWO_DRIVE_EN}),
        .gen_in(gen_seen),
        .pad_in(pad_sync),
        .pad_out(pad_out),
        .pad_oe(pad_oe),
        .bus_in(bus_sync),
        .bus_out(bus_out),
        .bus_oe(bus_oe)
    );

    // split packed vectors back onto per-pin ports
    assign GENERAL_PIN_THREE_SEEN = gen_seen[1];
    assign GENERAL_PIN_TWO_SEEN = gen_seen[0];
    assign GENERAL_PIN_THREE_OUT = pad_out[1];
    assign GENERAL_PIN_THREE_OE = pad_oe[1];
    assign GENERAL_PIN_TWO_OUT = pad_out[0];
    assign GENERAL_PIN_TWO_OE = pad_oe[0];
    assign EEPROM_CLOCK_OUT = bus_out[1];
    assign EEPROM_CLOCK_OE = bus_oe[1];
    assign EEPROM_DATA_OUT = bus_out[0];
    assign EEPROM_DATA_OE = bus_oe[0];

endmodule

// *** core/hmc_pkg.sv ***
// package for the host miscellaneous configuration register block:
// offsets, field positions, reset value and pin timing constants.
// assumes a 32-bit configuration data path with dword-aligned byte addresses.
package hmc_pkg;

    // configuration space placement
    localparam logic [7:0] HMC_MISC_OFFSET = 8'hf0;
    localparam logic [7:0] HMC_PM_CAP_OFFSET = 8'h46;

    // field positions inside the miscellaneous configuration register
    localparam int HMC_BIT_WAKE_COLD = 15;
    localparam int HMC_BIT_WAKE_LOW = 13;
    localparam int HMC_BIT_LOW_STATE = 10;
    localparam int HMC_BIT_NO_ABORT = 4;
    localparam int HMC_BIT_PIN_ROUTE = 3;
    localparam int HMC_BIT_LINK_BYPASS = 2;
    localparam int HMC_BIT_HOST_BYPASS = 1;
    localparam int HMC_BIT_KEEP_CLOCK = 0;

    // writable bits; everything else is reserved and reads zero
    localparam logic [31:0] HMC_WRITE_MASK = 32'h0000a41f;
    localparam logic [31:0] HMC_RESET_VALUE = 32'h00002400;

    // answer to an access of a stopped link-domain register
    localparam logic [31:0] HMC_ALL_ONES = 32'hffffffff;

    // width of the two-wire pin group
    localparam int HMC_PIN_COUNT = 2;

    // clock run request: hold the line low this long once a stop is seen
    localparam int HMC_CLKRUN_HOLD_NS = 10;
    localparam int HMC_CLOCK_PERIOD_PS = 5000;
    localparam int HMC_CLKRUN_HOLD_CYCLES =
        ((HMC_CLKRUN_HOLD_NS * 1000 + HMC_CLOCK_PERIOD_PS - 1) / HMC_CLOCK_PERIOD_PS) < 1 ? 1 :
        ((HMC_CLKRUN_HOLD_NS * 1000 + HMC_CLOCK_PERIOD_PS - 1) / HMC_CLOCK_PERIOD_PS);

endpackage

// *** core/hmc_clock_keeper.sv ***
// clock run keeper: pulls the shared open-drain clock run line low when
// the central resource tries to stop the clock and keeping is enabled.
// assumes the line input has already passed a two-stage synchroniser.
`timescale 1ns/1ps
module hmc_clock_keeper
    import hmc_pkg::*;
#(
    parameter int HOLD_CYCLES = HMC_CLKRUN_HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic keep_enable,
    input wire logic line_high,
    output logic line_drive_low
);

    typedef enum logic [1:0] {HMC_IDLE, HMC_HOLD, HMC_RELEASE} hmc_keep_t;

    hmc_keep_t state;
    hmc_keep_t next_state;
    logic [7:0] count;
    logic [7:0] next_count;
    wire logic stop_attempt = line_high;

    // line high means the central resource has released it to stop the clock
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            HMC_IDLE: begin
                if (keep_enable && stop_attempt) begin // RULE_14
                    next_state = HMC_HOLD;
                    next_count = 8'(HOLD_CYCLES - 1);
                end
            end
            HMC_HOLD: begin
                if (count == 8'h00) begin
                    next_state = HMC_RELEASE;
                end else begin
                    next_count = count - 8'h01;
                end
            end
            // wait one cycle so our own release is not taken as a new stop
            HMC_RELEASE: begin
                next_state = HMC_IDLE;
            end
            default: begin
                next_state = HMC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= HMC_IDLE;
            count <= 8'h00;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // never drive while keeping is off, so the clock may be stopped
    assign line_drive_low = (state == HMC_HOLD) && keep_enable; // RULE_15

endmodule

// *** core/hmc_pin_router.sv ***
// pin router: sends the general pin drivers either to their own pads or,
// when routing is on, onto the serial eeprom two-wire lines.
// assumes bus and pad inputs are already synchronised by the caller.
`timescale 1ns/1ps
module hmc_pin_router
    import hmc_pkg::*;
#(
    parameter int COUNT = HMC_PIN_COUNT
) (
    input wire logic route,
    input wire logic [COUNT-1:0] gen_out,
    input wire logic [COUNT-1:0] gen_oe,
    output logic [COUNT-1:0] gen_in,
    input wire logic [COUNT-1:0] pad_in,
    output logic [COUNT-1:0] pad_out,
    output logic [COUNT-1:0] pad_oe,
    input wire logic [COUNT-1:0] bus_in,
    output logic [COUNT-1:0] bus_out,
    output logic [COUNT-1:0] bus_oe
);

    genvar i;
    generate
        for (i = 0; i < COUNT; i = i + 1) begin : g_pin
            // routed: pad released, driver lands on the bus line
            assign pad_out[i] = gen_out[i];
            assign pad_oe[i] = gen_oe[i] && !route; // RULE_10
            assign bus_out[i] = gen_out[i];
            assign bus_oe[i] = gen_oe[i] && route; // RULE_09
            assign gen_in[i] = route ? bus_in[i] : pad_in[i]; // RULE_09
        end
    endgenerate

endmodule

// *** bench/hmc_misc_config_monitor.sv ***
// checker for the miscellaneous configuration register block ports.
// assumes single-cycle config and link strobes, bound to every instance.
`timescale 1ns/1ps
module hmc_misc_config_monitor
    import hmc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CFG_WRITE,
    input wire logic CFG_READ,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BYTE_EN,
    input wire logic [31:0] CFG_WDATA,
    input wire logic [31:0] CFG_RDATA,
    input wire logic WAKE_FROM_COLD_ADVERT,
    input wire logic WAKE_FROM_LOW_STATE_ADVERT,
    input wire logic LOW_STATE_ADVERT,
    input wire logic LINK_ACCESS,
    input wire logic LINK_CLOCK_RUNNING,
    input wire logic LINK_ACCESS_DONE,
    input wire logic LINK_TARGET_ABORT,
    input wire logic [31:0] LINK_ACCESS_RDATA,
    input wire logic HOST_CLOCK_GATE_REQ,
    input wire logic LINK_CLOCK_GATE_REQ,
    input wire logic HOST_CLOCK_GATE_OPEN,
    input wire logic LINK_CLOCK_GATE_OPEN,
    input wire logic CLKRUN_IN,
    input wire logic CLKRUN_OE,
    input wire logic GENERAL_PIN_THREE_DRIVE_EN,
    input wire logic GENERAL_PIN_TWO_DRIVE_EN,
    input wire logic GENERAL_PIN_THREE_OE,
    input wire logic GENERAL_PIN_TWO_OE,
    input wire logic EEPROM_CLOCK_OE,
    input wire logic EEPROM_DATA_OE
);
    logic [15:0] sh;
    wire logic [15:0] wm = {{8{CFG_BYTE_EN[1]}}, {8{CFG_BYTE_EN[0]}}} & HMC_WRITE_MASK[15:0];
    wire logic hit = CFG_WRITE && CFG_ADDR == HMC_MISC_OFFSET;
    wire logic cold_in = CFG_WDATA[15];
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the writable fields, same edge as the real register
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sh <= HMC_RESET_VALUE[15:0];
        end else if (hit) begin
            sh <= (sh & ~wm) | (CFG_WDATA[15:0] & wm);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    // status needs three low samples, the synchroniser eats two
    sequence link_stopped;
        !LINK_CLOCK_RUNNING [*3] ##0 LINK_ACCESS;
    endsequence
    sequence line_rise;
        !CLKRUN_IN ##1 (CLKRUN_IN && sh[0] && !CLKRUN_OE) [*3];
    endsequence
    chk_read_value: assert property (
        CFG_READ && CFG_ADDR == HMC_MISC_OFFSET |=> CFG_RDATA == {16'h0000, $past(sh)})
        else $error("read value mismatch");
    chk_reserved_zero: assert property (
        CFG_READ |=> (CFG_RDATA & ~HMC_WRITE_MASK) == 32'h00000000)
        else $error("reserved bits set");
    chk_cold_mirror: assert property (
        hit && CFG_BYTE_EN[1] |=> WAKE_FROM_COLD_ADVERT == $past(cold_in))
        else $error("cold advert wrong");
    chk_low_wake_mirror: assert property (WAKE_FROM_LOW_STATE_ADVERT == sh[13])
        else $error("low wake advert wrong");
    chk_low_state_mirror: assert property (LOW_STATE_ADVERT == sh[10])
        else $error("low state advert wrong");
    chk_stop_abort: assert property (
        link_stopped ##0 !sh[4] |=> LINK_TARGET_ABORT && !LINK_ACCESS_DONE)
        else $error("no abort on stopped link");
    chk_stop_ones: assert property (
        link_stopped ##0 sh[4] |=> LINK_ACCESS_DONE && !LINK_TARGET_ABORT
        && LINK_ACCESS_RDATA == HMC_ALL_ONES)
        else $error("no ones on stopped link");
    chk_route_bus: assert property (sh[3] |-> EEPROM_CLOCK_OE == GENERAL_PIN_THREE_DRIVE_EN
        && EEPROM_DATA_OE == GENERAL_PIN_TWO_DRIVE_EN)
        else $error("bus drive wrong");
    chk_route_release: assert property (
        sh[3] |-> !GENERAL_PIN_THREE_OE && !GENERAL_PIN_TWO_OE)
        else $error("pads driven while routed");
    chk_link_gate: assert property (
        LINK_CLOCK_GATE_OPEN == (sh[2] | LINK_CLOCK_GATE_REQ))
        else $error("link gate wrong");
    chk_host_gate: assert property (
        HOST_CLOCK_GATE_OPEN == (sh[1] | HOST_CLOCK_GATE_REQ))
        else $error("host gate wrong");
    chk_keep_drive: assert property (line_rise |=> CLKRUN_OE)
        else $error("clock run not held");
    chk_stop_allowed: assert property (!sh[0] |-> !CLKRUN_OE)
        else $error("clock run driven");
endmodule
bind hmc_misc_config hmc_misc_config_monitor mon (.*);

// *** bench/hmc_host_model.sv ***
// configuration software model: single-cycle config reads and writes.
// assumes the register answers a read one cycle after the strobe.
`timescale 1ns/1ps
module hmc_host_model
    import hmc_pkg::*;
(
    input wire logic clock,
    output logic cfg_write,
    output logic cfg_read,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_wdata,
    input wire logic cfg_read_valid,
    input wire logic [31:0] cfg_rdata
);
    initial begin
        {cfg_write, cfg_read, cfg_addr, cfg_byte_en, cfg_wdata} = '0;
    end
    // released write data and read address get inverted values so a late sample cannot pass
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clock);
        cfg_write <= 1'b1;
        cfg_addr <= a;
        cfg_byte_en <= be;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_write <= 1'b0;
        cfg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
        @(posedge clock);
        cfg_read <= 1'b1;
        cfg_addr <= a;
        @(posedge clock);
        cfg_read <= 1'b0;
        cfg_addr <= ~a;
        @(negedge clock);
        v = cfg_read_valid;
        d = cfg_rdata;
    endtask
    // usual setup: no-abort mode on, both bypass bits kept clear
    task automatic setup(input logic keep);
        wr(HMC_MISC_OFFSET, 4'h1, {27'h0, 1'b1, 3'b000, keep});
    endtask
endmodule

// *** bench/tb_pci_misc_configuration.sv ***
// testbench for the miscellaneous configuration register block.
// assumes the host model in the bench folder and the bound checker.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_pci_misc_configuration
    import hmc_pkg::*;
;
    logic CLOCK, RST, link_acc, link_rd, link_run, hreq, lreq, central_hi, d3, e3, d2, e2;
    logic cfg_w, cfg_r, rv, wc, wl, ls, ldone, labort, hopen, lopen, koe, p3oe, p2oe, ecoe, edoe;
    logic p3i, p2i, eci, edi, s3, s2, p3o, p2o, eco, edo, ko;
    logic [7:0] cfg_a;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wd, rdata, lrdata, link_data, model, r;
    int error_cnt, tests_run, i, n;
    wire logic clkrun_line = central_hi & ~koe;
    hmc_host_model host (.clock(CLOCK), .cfg_write(cfg_w), .cfg_read(cfg_r), .cfg_addr(cfg_a),
        .cfg_byte_en(cfg_be), .cfg_wdata(cfg_wd), .cfg_read_valid(rv), .cfg_rdata(rdata));
    hmc_misc_config dut (.CLOCK(CLOCK), .RST(RST), .CFG_WRITE(cfg_w), .CFG_READ(cfg_r),
        .CFG_ADDR(cfg_a), .CFG_BYTE_EN(cfg_be), .CFG_WDATA(cfg_wd), .CFG_READ_VALID(rv),
        .CFG_RDATA(rdata), .WAKE_FROM_COLD_ADVERT(wc), .WAKE_FROM_LOW_STATE_ADVERT(wl),
        .LOW_STATE_ADVERT(ls), .LINK_ACCESS(link_acc), .LINK_ACCESS_READ(link_rd),
        .LINK_READ_DATA(link_data), .LINK_CLOCK_RUNNING(link_run), .LINK_ACCESS_DONE(ldone),
        .LINK_TARGET_ABORT(labort), .LINK_ACCESS_RDATA(lrdata), .HOST_CLOCK_GATE_REQ(hreq),
        .LINK_CLOCK_GATE_REQ(lreq), .HOST_CLOCK_GATE_OPEN(hopen), .LINK_CLOCK_GATE_OPEN(lopen),
        .CLKRUN_IN(clkrun_line), .CLKRUN_OUT(ko), .CLKRUN_OE(koe), .GENERAL_PIN_THREE_DRIVE(d3),
        .GENERAL_PIN_THREE_DRIVE_EN(e3), .GENERAL_PIN_TWO_DRIVE(d2),
        .GENERAL_PIN_TWO_DRIVE_EN(e2), .GENERAL_PIN_THREE_SEEN(s3), .GENERAL_PIN_TWO_SEEN(s2),
        .GENERAL_PIN_THREE_IN(p3i), .GENERAL_PIN_THREE_OUT(p3o), .GENERAL_PIN_THREE_OE(p3oe),
        .GENERAL_PIN_TWO_IN(p2i), .GENERAL_PIN_TWO_OUT(p2o), .GENERAL_PIN_TWO_OE(p2oe),
        .EEPROM_CLOCK_IN(eci), .EEPROM_CLOCK_OUT(eco), .EEPROM_CLOCK_OE(ecoe),
        .EEPROM_DATA_IN(edi), .EEPROM_DATA_OUT(edo), .EEPROM_DATA_OE(edoe));
    ////////////////////////////////////////////////////////////////////////////////
    // expected register after a write; bytes 2 and 3 hold only reserved bits
    function automatic logic [31:0] next_reg(logic [31:0] o, logic [3:0] be, logic [31:0] d);
        logic [31:0] m;
        m = {16'h0, {8{be[1]}}, {8{be[0]}}} & HMC_WRITE_MASK;
        return (o & ~m) | (d & m);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        host.wr(a, be, d);
        if (a == HMC_MISC_OFFSET) model = next_reg(model, be, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic v;
        host.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask
    // link status held three cycles so the synchroniser has settled
    task automatic link(input logic run, input logic rd, input logic [31:0] d,
        input logic dn, input logic ab, input logic [31:0] e);
        @(posedge CLOCK);
        link_run <= run;
        repeat (3) @(posedge CLOCK);
        link_acc <= 1'b1;
        link_rd <= rd;
        link_data <= d;
        @(posedge CLOCK);
        link_acc <= 1'b0;
        link_data <= ~d;
        @(negedge CLOCK);
        `CHK({ldone, labort, lrdata}, {dn, ab, e})
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    initial begin
        {RST, link_acc, link_rd, link_run, hreq, lreq, central_hi, d3, e3, d2, e2} = 11'h400;
        {p3i, p2i, eci, edi} = 4'h0;
        link_data = '0;
        error_cnt = 0;
        tests_run = 0;
        model = HMC_RESET_VALUE;
        void'($urandom(92736));
        repeat (20) @(posedge CLOCK);
        RST <= 1'b0;
        rd_chk(HMC_MISC_OFFSET, HMC_RESET_VALUE);
        rd_chk(8'h44, 32'h0);
        // all ones, all zeros, then random writes, a third off the register
        for (i = 0; i < 30; i++) begin
            @(posedge CLOCK);
            {hreq, lreq, e3, e2, d3, d2, p3i, p2i, eci, edi} <= 10'($urandom);
            r = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom;
            wr((i % 3 == 2) ? 8'($urandom) : HMC_MISC_OFFSET, (i < 2) ? 4'hf : 4'($urandom), r);
            rd_chk(HMC_MISC_OFFSET, model);
            `CHK({wc, wl, ls}, {model[15], model[13], model[10]})
            `CHK({hopen, lopen}, {model[1] | hreq, model[2] | lreq})
            `CHK({p3oe, p2oe, ecoe, edoe}, model[3] ? {2'b00, e3, e2} : {e3, e2, 2'b00})
            `CHK({s3, s2}, model[3] ? {eci, edi} : {p3i, p2i})
            `CHK({p3o, p2o, eco, edo, ko}, {d3, d2, d3, d2, 1'b0})
        end
        for (i = 0; i < 2; i++) begin
            wr(HMC_MISC_OFFSET, 4'h1, {27'h0, i[0], 4'h0});
            link(1'b0, i[0], $urandom, i[0], !i[0], i[0] ? HMC_ALL_ONES : 32'h0);
        end
        r = $urandom;
        link(1'b1, 1'b1, r, 1'b1, 1'b0, r);
        link(1'b1, 1'b0, r, 1'b1, 1'b0, 32'h0);
        // clock run: line raised by the central resource, counted at negedges
        host.setup(1'b1);
        @(posedge CLOCK);
        central_hi <= 1'b1;
        n = 0;
        do begin
            @(negedge CLOCK);
            n++;
        end while (!koe && n < 10);
        `CHK(n, 4)
        if (n >= 10) tally_and_finish();
        @(posedge CLOCK);
        central_hi <= 1'b0;
        host.setup(1'b0);
        @(posedge CLOCK);
        central_hi <= 1'b1;
        n = 0;
        repeat (10) begin
            @(negedge CLOCK);
            n += koe;
        end
        `CHK(n, 0)
        tally_and_finish();
    end
endmodule
